// ==== rtl/frc_consts.vh ====
`ifndef FRC_CONSTS_VH
`define FRC_CONSTS_VH
`define FRC_ADDR_W 4
`define FRC_ADDR_CTRL 4'h0
`define FRC_ADDR_STAT 4'h1
`define FRC_ADDR_TEMP 4'h2
`define FRC_ADDR_TICK 4'h3
`define FRC_BIT_EN 7
`define FRC_BIT_RDY 6
`define FRC_BIT_TEMP_SENSE_ENABLE 5
`define FRC_BIT_TEMP_RANGE_SELECT 4
`define FRC_CDA_HI 3
`define FRC_CDA_LO 2
`define FRC_ADC_HI 1
`define FRC_ADC_LO 0
`define FRC_CTRL_RST 8'h00
`define FRC_CTRL_WMASK 8'hBF
`define FRC_GAIN_OFF 2'h0
`define FRC_GAIN_1X 2'h1
`define FRC_GAIN_2X 2'h2
`define FRC_GAIN_4X 2'h3
`define FRC_BUF_SETTLE_NS 30000
`define FRC_TEMP_ACQ_NS 200000
`define FRC_CLK_NS 10
`define FRC_CNT_W 16
`define FRC_TEMP_CHAN 6'h1D
`define FRC_FLAGS_W 2
`define FRC_FLAGS_RST 2'h0
`define FRC_RDATA_RST 8'h00
`define FRC_ST_ADC 0
`define FRC_ST_CDA 1
`define FRC_ST_REF 2
`define FRC_ST_RDY 3
`define FRC_TF_SEL 0
`define FRC_TF_GAP 1
`define FRC_TF_OK 2
`endif

// ==== rtl/frc_settle.v ====
`include "frc_consts.vh"
`default_nettype none
module frc_settle (
	input wire clock_i,
	input wire rstn_i,
	input wire start_i,
	input wire hold_i,
	input wire [`FRC_CNT_W-1:0] len_i,
	output reg done_o
);
	reg [`FRC_CNT_W-1:0] cnt_q;
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= {`FRC_CNT_W{1'b0}};
			done_o <= 1'b0;
		end else if (!hold_i || start_i) begin
			cnt_q <= {`FRC_CNT_W{1'b0}};
			done_o <= 1'b0;
		end else if (!done_o) begin
			if (cnt_q + 1'b1 >= len_i)
				done_o <= 1'b1;
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule // frc_settle
`default_nettype wire

// ==== rtl/frc_top.v ====
// Function
// - Reference powered while enable bit set, off while clear.
// - Two independent gain buffers: converter path and DAC/comparator path.
// - Ready bit sets after reference and buffers settle.
// - Converter gain: 11 is 4x, 10 is 2x, 01 is 1x, 00 off.
// - DAC/comparator gain uses same encoding, independent field.
// - Temperature indicator on while sensor enable bit set.
// - Range bit one selects high range, zero low range.
// - Indicator output appears on a reserved converter channel.
`include "frc_consts.vh"
`default_nettype none
module frc_top #(
	parameter [`FRC_CNT_W-1:0] REF_SETTLE_CYC = 16'h0064
) (
	input wire clock_i,
	input wire rstn_i,
	input wire [`FRC_ADDR_W-1:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire [5:0] adc_chan_i,
	input wire adc_conv_start_i,
	output wire ref_power_o,
	output wire [1:0] adc_gain_o,
	output wire adc_buf_on_o,
	output wire [1:0] cda_gain_o,
	output wire cda_buf_on_o,
	output wire temp_on_o,
	output wire temp_high_range_o,
	output wire temp_on_chan_o,
	output wire temp_acq_ok_o
);
	// Spans in clock cycles, rounded up so a wait is never cut short
	localparam integer BUF_CYC_I =
		(`FRC_BUF_SETTLE_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS;
	localparam integer ACQ_CYC_I =
		(`FRC_TEMP_ACQ_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS;
	localparam [`FRC_CNT_W-1:0] BUF_CYC = BUF_CYC_I[`FRC_CNT_W-1:0];
	localparam [`FRC_CNT_W-1:0] ACQ_CYC = ACQ_CYC_I[`FRC_CNT_W-1:0];
	localparam integer NBUF = 2;
	localparam integer GW = 2;

	reg [7:0] ctrl_q;
	reg [7:0] ctrl_d;
	reg [NBUF*GW-1:0] gain_prev_q;
	reg [`FRC_FLAGS_W-1:0] acq_flags_q;
	reg [`FRC_FLAGS_W-1:0] acq_flags_d;
	reg [7:0] rdata_d;
	reg [7:0] ctrl_rd;
	reg [7:0] stat_rd;
	reg [7:0] temp_rd;
	reg ref_power_q;
	reg [GW-1:0] adc_gain_q;
	reg [GW-1:0] cda_gain_q;
	reg adc_buf_on_q;
	reg cda_buf_on_q;
	reg temp_on_q;
	reg temp_range_q;

	wire wr_ctrl;
	wire wr_temp;
	wire ref_en;
	wire [GW-1:0] adc_g;
	wire [GW-1:0] cda_g;
	wire [GW-1:0] adc_g_d;
	wire [GW-1:0] cda_g_d;
	wire adc_buf_on_d;
	wire cda_buf_on_d;
	wire [NBUF*GW-1:0] buf_gain;
	wire [NBUF-1:0] buf_on;
	wire [NBUF-1:0] buf_start;
	wire [NBUF-1:0] buf_done;
	wire ref_start;
	wire ref_done;
	wire adc_done;
	wire cda_done;
	wire sel_done;
	wire gap_done;
	wire on_chan;
	wire ready;

	assign wr_ctrl = wr_i && (addr_i == `FRC_ADDR_CTRL);
	assign wr_temp = wr_i && (addr_i == `FRC_ADDR_TEMP);
	assign ref_en = ctrl_q[`FRC_BIT_EN];
	assign adc_g = ctrl_q[`FRC_ADC_HI:`FRC_ADC_LO];
	assign cda_g = ctrl_q[`FRC_CDA_HI:`FRC_CDA_LO];
	assign buf_gain = {cda_g, adc_g};
	// Only a rising enable restarts the reference; rewrites while on do not
	assign ref_start = wr_ctrl && wdata_i[`FRC_BIT_EN] && !ref_en;
	assign on_chan = (adc_chan_i == `FRC_TEMP_CHAN);

	// Next control value; the ready bit is never writable
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = wdata_i & `FRC_CTRL_WMASK;
	end

	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			ctrl_q <= `FRC_CTRL_RST;
		else
			ctrl_q <= ctrl_d;
	end

	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			gain_prev_q <= {NBUF{`FRC_GAIN_OFF}};
		else
			gain_prev_q <= buf_gain;
	end

	// Output flops load from the next control value, so they track ctrl_q
	// with no extra cycle of lag
	assign adc_g_d = ctrl_d[`FRC_ADC_HI:`FRC_ADC_LO];
	assign cda_g_d = ctrl_d[`FRC_CDA_HI:`FRC_CDA_LO];
	// Buffers are gated by the reference: no reference, nothing to amplify
	assign adc_buf_on_d = ctrl_d[`FRC_BIT_EN] &&
		(adc_g_d != `FRC_GAIN_OFF);
	assign cda_buf_on_d = ctrl_d[`FRC_BIT_EN] &&
		(cda_g_d != `FRC_GAIN_OFF);

	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ref_power_q <= 1'b0;
			adc_gain_q <= `FRC_GAIN_OFF;
			cda_gain_q <= `FRC_GAIN_OFF;
			adc_buf_on_q <= 1'b0;
			cda_buf_on_q <= 1'b0;
			temp_on_q <= 1'b0;
			temp_range_q <= 1'b0;
		end else begin
			ref_power_q <= ctrl_d[`FRC_BIT_EN];
			adc_gain_q <= adc_g_d;
			cda_gain_q <= cda_g_d;
			adc_buf_on_q <= adc_buf_on_d;
			cda_buf_on_q <= cda_buf_on_d;
			temp_on_q <= ctrl_d[`FRC_BIT_TEMP_SENSE_ENABLE];
			temp_range_q <= ctrl_d[`FRC_BIT_TEMP_RANGE_SELECT];
		end
	end

	assign ref_power_o = ref_power_q;
	assign adc_gain_o = adc_gain_q;
	assign cda_gain_o = cda_gain_q;
	assign adc_buf_on_o = adc_buf_on_q;
	assign cda_buf_on_o = cda_buf_on_q;
	assign temp_on_o = temp_on_q;
	assign temp_high_range_o = temp_range_q;
	// Channel select is a live input, so this flag follows it at once
	assign temp_on_chan_o = temp_on_q && on_chan;

	frc_settle u_ref (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.start_i(ref_start),
		.hold_i(ref_en),
		.len_i(REF_SETTLE_CYC),
		.done_o(ref_done)
	);

	// One settle timer per gain buffer; a new code or a fresh reference
	// enable restarts it, so ready drops while the buffer re-settles
	genvar b;
	generate
		for (b = 0; b < NBUF; b = b + 1) begin : g_buf
			wire [GW-1:0] code;
			wire [GW-1:0] code_prev;
			assign code = buf_gain[b*GW +: GW];
			assign code_prev = gain_prev_q[b*GW +: GW];
			assign buf_on[b] = ref_en && (code != `FRC_GAIN_OFF);
			assign buf_start[b] = (code != code_prev) || ref_start;
			frc_settle u_settle (
				.clock_i(clock_i),
				.rstn_i(rstn_i),
				.start_i(buf_start[b]),
				.hold_i(1'b1),
				.len_i(BUF_CYC),
				.done_o(buf_done[b])
			);
		end
	endgenerate

	assign adc_done = buf_done[0];
	assign cda_done = buf_done[1];

	assign ready = ref_en && ref_done &&
		(adc_done || !buf_on[0]) && (cda_done || !buf_on[1]);

	// Acquisition guard: status only, conversions are never blocked
	frc_settle u_sel (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.start_i(1'b0),
		.hold_i(temp_on_chan_o),
		.len_i(ACQ_CYC),
		.done_o(sel_done)
	);
	frc_settle u_gap (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.start_i(adc_conv_start_i),
		.hold_i(1'b1),
		.len_i(ACQ_CYC),
		.done_o(gap_done)
	);
	assign temp_acq_ok_o = sel_done && gap_done;

	// Sticky violation flags; a violation in the clearing cycle wins
	always @* begin
		acq_flags_d = acq_flags_q;
		if (wr_temp)
			acq_flags_d = acq_flags_q & ~wdata_i[`FRC_TF_GAP:`FRC_TF_SEL];
		if (adc_conv_start_i && temp_on_chan_o) begin
			if (!sel_done)
				acq_flags_d[`FRC_TF_SEL] = 1'b1;
			if (!gap_done)
				acq_flags_d[`FRC_TF_GAP] = 1'b1;
		end
	end

	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			acq_flags_q <= `FRC_FLAGS_RST;
		else
			acq_flags_q <= acq_flags_d;
	end

	// Control view: live ready replaces the unwritable bit
	always @* begin
		ctrl_rd = ctrl_q;
		ctrl_rd[`FRC_BIT_RDY] = ready;
	end

	always @* begin
		stat_rd = `FRC_RDATA_RST;
		stat_rd[`FRC_ST_ADC] = adc_done;
		stat_rd[`FRC_ST_CDA] = cda_done;
		stat_rd[`FRC_ST_REF] = ref_done;
		stat_rd[`FRC_ST_RDY] = ready;
	end

	always @* begin
		temp_rd = `FRC_RDATA_RST;
		temp_rd[`FRC_TF_SEL] = acq_flags_q[`FRC_TF_SEL];
		temp_rd[`FRC_TF_GAP] = acq_flags_q[`FRC_TF_GAP];
		temp_rd[`FRC_TF_OK] = temp_acq_ok_o;
	end

	// Read data stand for one cycle only, zero otherwise
	always @* begin
		rdata_d = `FRC_RDATA_RST;
		if (rd_i) begin
			case (addr_i)
			`FRC_ADDR_CTRL: rdata_d = ctrl_rd;
			`FRC_ADDR_STAT: rdata_d = stat_rd;
			`FRC_ADDR_TEMP: rdata_d = temp_rd;
			default: rdata_d = `FRC_RDATA_RST;
			endcase
		end
	end

	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			rdata_o <= `FRC_RDATA_RST;
		else
			rdata_o <= rdata_d;
	end
endmodule // frc_top
`default_nettype wire

// ==== test/frc_far.sv ====
`default_nettype none
module frc_far (
	input wire clock_i,
	output logic [5:0] adc_chan_i,
	output logic adc_conv_start_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial adc_chan_i = 6'h00;
	initial adc_conv_start_i = 1'h0;
	task sel(input [5:0] c);
		adc_chan_i <= c;
	endtask
	// The caller picks the gap; zero breaks the spacing on purpose
	task conv(input int gap);
		repeat (gap + 1) @(posedge clock_i);
		adc_conv_start_i <= 1'h1;
		@(posedge clock_i);
		adc_conv_start_i <= 1'h0;
	endtask
endmodule // frc_far
`default_nettype wire

// ==== test/frc_chk_asserts.sv ====
`default_nettype none
module frc_chk (
	input wire clock_i,
	input wire rstn_i,
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	input wire [5:0] adc_chan_i,
	input wire ref_power_o,
	input wire [1:0] adc_gain_o,
	input wire adc_buf_on_o,
	input wire [1:0] cda_gain_o,
	input wire cda_buf_on_o,
	input wire temp_on_o,
	input wire temp_high_range_o,
	input wire temp_on_chan_o
);
	wire cw = wr_i && addr_i == 4'h0;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	a_ref_write: assert property (cw |=> ref_power_o == $past(wdata_i[7]))
		else $error("ref power");
	a_ctrl_hold: assert property (!cw |=> $stable({ref_power_o,
		adc_gain_o, cda_gain_o, temp_on_o, temp_high_range_o})) else $error("hold");
	a_gain_write: assert property (cw |=> {cda_gain_o, adc_gain_o} ==
		$past(wdata_i[3:0])) else $error("gain");
	a_adc_buf: assert property (adc_buf_on_o == (ref_power_o && |adc_gain_o))
		else $error("adc buf");
	a_cda_buf: assert property (cda_buf_on_o == (ref_power_o && |cda_gain_o))
		else $error("cda buf");
	a_temp_write: assert property (cw |=> {temp_on_o, temp_high_range_o} ==
		$past(wdata_i[5:4])) else $error("temp");
	a_temp_chan: assert property (temp_on_chan_o ==
		(temp_on_o && adc_chan_i == 6'h1D)) else $error("chan");
	a_ready_drop: assert property (cw && !wdata_i[7] ##[1:2] rd_i &&
		addr_i == 4'h0 |=> !rdata_o[6]) else $error("ready");
	cover property (cw && wdata_i[7]);
	cover property (temp_on_chan_o);
	cover property (adc_buf_on_o && cda_buf_on_o);
endmodule // frc_chk
bind frc_top frc_chk u_chk (.*);
`default_nettype wire

// ==== test/tb_top.sv ====
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'h0, rstn_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	wire [7:0] rdata_o;
	wire [5:0] adc_chan_i;
	wire [1:0] adc_gain_o, cda_gain_o;
	wire adc_conv_start_i, ref_power_o, adc_buf_on_o, cda_buf_on_o;
	wire temp_on_o, temp_high_range_o, temp_on_chan_o, temp_acq_ok_o;
	wire [11:0] outs = {ref_power_o, adc_buf_on_o, cda_buf_on_o, temp_on_o,
		temp_high_range_o, temp_on_chan_o, temp_acq_ok_o, 1'h0, cda_gain_o,
		adc_gain_o};
	int checks = 0, num_errors = 0;
	// Short reference settle keeps the run brief; buffers still need 3000
	frc_top #(.REF_SETTLE_CYC(16'h0010)) dut (.*);
	frc_far far (.*);
	initial forever #5 clock_i = ~clock_i;
	task chk(input [11:0] g, input [11:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge clock_i);
		wr_i <= 1'h0;
		#1;
	endtask
	task rd(input [3:0] a, input [7:0] m, input [7:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clock_i);
		rd_i <= 1'h0;
		#1 chk({4'h0, rdata_o & m}, {4'h0, e});
	endtask
	task t_ref;
		rd(4'h0, 8'hFF, 8'h00);
		rd(4'hF, 8'hFF, 8'h00);
		wr(4'h0, 8'h83);
		chk(outs, 12'hC03);
		rd(4'h0, 8'hFF, 8'h83);
		repeat (3100) @(posedge clock_i);
		rd(4'h0, 8'hFF, 8'hC3);
		wr(4'h0, 8'h45);
		chk(outs, 12'h005);
		rd(4'h0, 8'hFF, 8'h05);
		$display("reference test done");
	endtask
	task t_gain;
		logic [1:0] i;
		for (int j = 0; j < 4; j++) begin
			i = j[1:0];
			wr(4'h0, {4'h8, i, i});
			chk(outs, {1'h1, |i, |i, 5'h00, i, i});
		end
		$display("gain test done");
	endtask
	task t_temp;
		wr(4'h0, 8'h30);
		chk(outs, 12'h180);
		@(posedge clock_i);
		far.sel(6'h1D);
		#1 chk(outs, 12'h1C0);
		repeat (20010) @(posedge clock_i);
		#1 chk(outs, 12'h1E0);
		far.conv(0);
		#1 chk(outs, 12'h1C0);
		far.conv(0);
		rd(4'h2, 8'h02, 8'h02);
		wr(4'h2, 8'h03);
		rd(4'h2, 8'h03, 8'h00);
		@(posedge clock_i);
		far.sel(6'h00);
		@(posedge clock_i);
		far.sel(6'h1D);
		far.conv(0);
		rd(4'h2, 8'h01, 8'h01);
		wr(4'h0, 8'h20);
		chk(outs, 12'h140);
		$display("temperature test done");
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock_i);
		rstn_i <= 1'h1;
		t_ref;
		t_gain;
		t_temp;
		wrap_up;
	end
	initial begin
		#400us;
		num_errors++;
		wrap_up;
	end
endmodule // tb_top
`default_nettype wire
